/* logic/dpm_host.sv */
// Port controller that drives one side of the dual-port memory
`timescale 1ns/1ps
`include "dpm_host_cfg.svh"
module dpm_host #(
  parameter int NUM_BUSY = 1,
  parameter bit IS_LEFT = 1'b1,
  parameter bit MAKE_MASTER = 1'b1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // User command
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_token_i,
  input wire logic [`HOST_ADDR_W-1:0] cmd_addr_i,
  input wire logic [`HOST_DATA_W-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  // User response
  output logic rsp_valid_o,
  output logic [`HOST_DATA_W-1:0] rsp_rdata_o,
  output logic rsp_blocked_o,
  output logic mail_pending_o,
  // Memory port pins
  output logic [`HOST_ADDR_W-1:0] addr_o,
  output logic mem_enable_n_o,
  output logic token_space_select_n_o,
  output logic rw_n_o,
  output logic oe_n_o,
  output logic [`HOST_DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [`HOST_DATA_W-1:0] data_i,
  input wire logic [NUM_BUSY-1:0] busy_n_i,
  input wire logic mail_flag_n_i,
  output logic role_master_o
);
  localparam int SETUP_CYC = `HOST_SETUP_CYC;
  localparam int STROBE_CYC = `HOST_STROBE_CYC;
  localparam int HOLD_CYC = `HOST_HOLD_CYC;
  localparam int SYNC_CYC = `HOST_SYNC_CYC;
  localparam int SW = NUM_BUSY + 1 + `HOST_DATA_W;
  localparam logic [`HOST_ADDR_W-1:0] OWN_MAILBOX =
    IS_LEFT ? `HOST_LEFT_MAILBOX : `HOST_RIGHT_MAILBOX;

  dpm_host_pkg::host_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic is_wr_r, is_wr_nxt;
  logic is_tok_r, is_tok_nxt;
  logic ready_nxt, rsp_valid_nxt, blocked_nxt;
  logic [`HOST_DATA_W-1:0] rdata_nxt, wdata_nxt;
  logic [`HOST_ADDR_W-1:0] addr_nxt;
  logic ce_n_nxt, sem_n_nxt, rw_n_nxt, oe_n_nxt, data_oe_nxt;
  logic [SW-1:0] sync_w;
  wire logic [NUM_BUSY-1:0] busy_sync = sync_w[NUM_BUSY-1:0];
  wire logic mail_sync_n = sync_w[NUM_BUSY];
  wire logic [`HOST_DATA_W-1:0] data_sync = sync_w[SW-1 -: `HOST_DATA_W];

  // Every pin input passes two flops; busy and mail idle high, as a tied-high slave pin [R14]
  dpm_pin_sync #(.W(SW), .RST_VAL({{`HOST_DATA_W{1'b0}}, {(NUM_BUSY + 1){1'b1}}})) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_i({data_i, mail_flag_n_i, busy_n_i}),
    .sync_o(sync_w)
  );

  // Depth-expanded parts: any low collision output means busy [R18]
  wire logic busy_clear = &busy_sync;
  wire logic cnt_done = (cnt_r == 4'h0);
  // Token accesses cover only the three index lines [R4]
  wire logic [`HOST_ADDR_W-1:0] cmd_pin_addr = cmd_token_i ?
    {{(`HOST_ADDR_W - `HOST_TOKEN_IDX_W){1'b0}}, cmd_addr_i[`HOST_TOKEN_IDX_W-1:0]} : cmd_addr_i;
  // Token writes carry only bit zero
  wire logic [`HOST_DATA_W-1:0] cmd_pin_data = cmd_token_i ?
    {{(`HOST_DATA_W - 1){1'b0}}, cmd_wdata_i[0]} : cmd_wdata_i;

  // Access sequencer: setup, strobe, hold, back to standby
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    is_wr_nxt = is_wr_r;
    is_tok_nxt = is_tok_r;
    ready_nxt = cmd_ready_o;
    rsp_valid_nxt = 1'b0;
    blocked_nxt = rsp_blocked_o;
    rdata_nxt = rsp_rdata_o;
    addr_nxt = addr_o;
    wdata_nxt = data_o;
    ce_n_nxt = mem_enable_n_o;
    sem_n_nxt = token_space_select_n_o;
    rw_n_nxt = rw_n_o;
    oe_n_nxt = oe_n_o;
    data_oe_nxt = data_oe_o;
    case (state_r)
      dpm_host_pkg::ST_IDLE: begin
        // Ready rises one edge after reset; a request seen before then is ignored
        ready_nxt = 1'b1;
        if (cmd_valid_i && cmd_ready_o) begin
          is_wr_nxt = cmd_write_i;
          is_tok_nxt = cmd_token_i;
          addr_nxt = cmd_pin_addr;
          wdata_nxt = cmd_pin_data;
          ce_n_nxt = cmd_token_i; // Token space keeps memory enable high [R5]
          sem_n_nxt = ~cmd_token_i; // [R5]
          data_oe_nxt = cmd_write_i;
          blocked_nxt = 1'b0;
          ready_nxt = 1'b0;
          cnt_nxt = 4'(SETUP_CYC - 1);
          state_nxt = dpm_host_pkg::ST_SETUP;
        end
      end
      dpm_host_pkg::ST_SETUP: begin
        // Address held so the master's flag settles before strobing [R16]
        if (!cnt_done) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (is_tok_r || busy_clear) begin // Stall while flagged [R10]
          rw_n_nxt = ~is_wr_r;
          oe_n_nxt = is_wr_r;
          cnt_nxt = is_wr_r ? 4'(STROBE_CYC - 1) : 4'(STROBE_CYC + SYNC_CYC - 1);
          state_nxt = dpm_host_pkg::ST_STROBE;
        end
      end
      dpm_host_pkg::ST_STROBE: begin
        // A write hit by busy mid-strobe was gated inside the part [R11]
        if (is_wr_r && !is_tok_r && !busy_clear) begin
          blocked_nxt = 1'b1;
        end
        if (!cnt_done) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          if (!is_wr_r) begin
            rdata_nxt = data_sync;
          end
          rw_n_nxt = 1'b1;
          oe_n_nxt = 1'b1; // Drops latched token value for the next read [R21]
          cnt_nxt = 4'(HOLD_CYC - 1);
          state_nxt = dpm_host_pkg::ST_HOLD;
        end
      end
      dpm_host_pkg::ST_HOLD: begin
        if (!cnt_done) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          ce_n_nxt = 1'b1; // Both selects high puts the port in standby [R6]
          sem_n_nxt = 1'b1;
          data_oe_nxt = 1'b0;
          rsp_valid_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = dpm_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = dpm_host_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r <= dpm_host_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      is_wr_r <= 1'b0;
      is_tok_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      is_wr_r <= is_wr_nxt;
      is_tok_r <= is_tok_nxt;
    end
  end

  // Pin drivers, all from flops; idle is deselected standby
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      addr_o <= 13'h0000;
      data_o <= 8'h00;
      mem_enable_n_o <= 1'b1;
      token_space_select_n_o <= 1'b1;
      rw_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      data_oe_o <= 1'b0;
    end else begin
      addr_o <= addr_nxt;
      data_o <= wdata_nxt;
      mem_enable_n_o <= ce_n_nxt;
      token_space_select_n_o <= sem_n_nxt;
      rw_n_o <= rw_n_nxt;
      oe_n_o <= oe_n_nxt;
      data_oe_o <= data_oe_nxt;
    end
  end

  // User side outputs; a single master per width group is a build choice
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
      rsp_blocked_o <= 1'b0;
      mail_pending_o <= 1'b0;
      role_master_o <= 1'b0;
    end else begin
      cmd_ready_o <= ready_nxt;
      rsp_valid_o <= rsp_valid_nxt;
      rsp_rdata_o <= rdata_nxt;
      rsp_blocked_o <= blocked_nxt;
      mail_pending_o <= ~mail_sync_n; // Cleared by reading OWN_MAILBOX
      role_master_o <= MAKE_MASTER; // [R17]
    end
  end

  // Checks on the pin sequence
  wire logic port_selected = !mem_enable_n_o || !token_space_select_n_o;

  sequence s_select_held;
    (!mem_enable_n_o || !token_space_select_n_o) [*3];
  endsequence

  property p_token_space;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !token_space_select_n_o |-> mem_enable_n_o;
  endproperty
  a_token_space: assert property (p_token_space) else $error("token select with memory enable"); // [R5]

  property p_setup_before_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $fell(rw_n_o) |-> $past(port_selected, `HOST_SETUP_CYC);
  endproperty
  a_setup_before_write: assert property (p_setup_before_write) else $error("write strobe too early"); // [R16]

  property p_strobe_on_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
      ($fell(rw_n_o) || $fell(oe_n_o)) && !mem_enable_n_o |-> $past(busy_clear);
  endproperty
  a_strobe_on_clear: assert property (p_strobe_on_clear) else $error("strobe while busy"); // [R18]

  property p_select_through_strobe;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $fell(rw_n_o) |-> s_select_held;
  endproperty
  a_select_through_strobe: assert property (p_select_through_strobe) else $error("select dropped in write"); // [R16]

  property p_write_length;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(rw_n_o) |-> !$past(rw_n_o, `HOST_STROBE_CYC);
  endproperty
  a_write_length: assert property (p_write_length) else $error("write strobe too short"); // [R16]

  property p_done_standby;
    @(posedge mclk_i) disable iff (!reset_n_i)
      rsp_valid_o |-> mem_enable_n_o && token_space_select_n_o && rw_n_o && !data_oe_o;
  endproperty
  a_done_standby: assert property (p_done_standby) else $error("port not deselected at end");

  property p_role_fixed;
    @(posedge mclk_i) disable iff (!reset_n_i)
      cmd_ready_o |-> role_master_o == MAKE_MASTER;
  endproperty
  a_role_fixed: assert property (p_role_fixed) else $error("role select not as built"); // [R17]
endmodule

/* logic/dpm_host_cfg.svh */
// Constants for the dual-port memory port controller
// Functional notes
// R1 - Free token written 0 by one side reads 0 there, 1 opposite.
// R2 - Token held: opposite side writing 0 changes no read value.
// R3 - Holder writes 1 with opposite request pending: token passes over.
// R4 - Eight tokens on three low address lines, bit 0 written, byte read.
// R5 - Token space needs memory enable high while token select low.
// R6 - Memory enable high means standby; both selects high means deselected.
// R7 - Left mail flag set by right write 1FFE, cleared by left read.
// R8 - Right mail flag set by left write 1FFF, cleared by right read.
// R9 - Mailbox words hold ordinary 8-bit data usable as plain memory.
// R10 - Same-location collision lets one access proceed, flags the other.
// R11 - Write from the flagged side is gated off internally.
// R12 - Role select high drives collision flags out; low takes them in.
// R13 - Slave collision pin low inhibits writes; high allows them.
// R14 - System ties slave collision input high, or low to block writes.
// R15 - Master collision decision uses enables and addresses only.
// R16 - Hold address and enable long enough before starting write strobe.
// R17 - Only one part in a width expansion may be master.
// R18 - Depth expansion ANDs per-part collision outputs into one flag.
// R19 - Tokens gate no memory access and add no wait states.
// R20 - Holder writes 1 without pending request: both sides read 1.
// R21 - Token read value latched while select and output enable active.
// R22 - Simultaneous requests: exactly one side wins, earlier one first.
// R23 - Master never drives both collision outputs low together.
`ifndef DPM_HOST_CFG_SVH
`define DPM_HOST_CFG_SVH

`define HOST_CLK_MHZ 250
`define HOST_SETUP_NS 20
`define HOST_STROBE_NS 20
`define HOST_HOLD_NS 10
`define HOST_SETUP_CYC ((`HOST_SETUP_NS * `HOST_CLK_MHZ + 999) / 1000)
`define HOST_STROBE_CYC ((`HOST_STROBE_NS * `HOST_CLK_MHZ + 999) / 1000)
`define HOST_HOLD_CYC ((`HOST_HOLD_NS * `HOST_CLK_MHZ + 999) / 1000)
`define HOST_SYNC_CYC 2
`define HOST_ADDR_W 13
`define HOST_DATA_W 8
`define HOST_TOKEN_IDX_W 3
`define HOST_LEFT_MAILBOX 13'h1FFE
`define HOST_RIGHT_MAILBOX 13'h1FFF

`endif

/* logic/dpm_host_pkg.sv */
// Types for the dual-port memory port controller
package dpm_host_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } host_state_t;
endpackage

/* logic/dpm_pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dpm_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Pins in, synchronised out
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
  end
endmodule

/* tb/dpm_port_model.sv */
// Behavioural two-port memory with tokens, mailbox flags and collision logic
`timescale 1ns/1ps
module dpm_port_model (
  // Port pins, index 0 is left, 1 is right
  input wire logic [12:0] addr_i [2],
  input wire logic [1:0] mem_enable_n_i,
  input wire logic [1:0] token_space_select_n_i,
  input wire logic [1:0] rw_n_i,
  input wire logic [1:0] oe_n_i,
  input wire logic [7:0] data_i [2],
  input wire logic role_master_i,
  // Pins back to the controllers
  output logic [7:0] data_o [2],
  output logic [1:0] busy_n_o,
  output logic [1:0] mail_flag_n_o
);
  logic [7:0] mem [8192];
  logic [7:0] req [2] = '{8'hFF, 8'hFF};
  logic [7:0] own [2] = '{8'h00, 8'h00};
  logic [7:0] tok [2];
  logic [7:0] hold [2];
  realtime t_on [2];
  wire match = !mem_enable_n_i[0] && !mem_enable_n_i[1] && addr_i[0] == addr_i[1];

  initial mail_flag_n_o = 2'b11;
  // Later side is flagged; a tie goes against the left so both never drop
  assign busy_n_o[0] = !(role_master_i && match && t_on[0] >= t_on[1]);
  assign busy_n_o[1] = !(role_master_i && match && t_on[1] > t_on[0]);

  // Request latch update, then hand the token to whoever asks first
  task automatic settle(input int s, input logic [2:0] i, input logic v);
    req[s][i] = v;
    if (v)
      own[s][i] = 1'b0;
    if (!own[0][i] && !own[1][i]) begin
      if (!req[s][i])
        own[s][i] = 1'b1;
      else if (!req[1-s][i])
        own[1-s][i] = 1'b1;
    end
  endtask

  for (genvar s = 0; s < 2; s++) begin : g_side
    wire rd = !oe_n_i[s] && !mem_enable_n_i[s];
    wire tr = token_space_select_n_i[s] | oe_n_i[s];
    // Arrival time of address and enable for the collision decision
    always @(addr_i[s] or mem_enable_n_i[s]) t_on[s] = $realtime;
    // Token value frozen while the read is open
    always @(negedge tr) tok[s] = {8{!own[s][addr_i[s][2:0]]}};
    // Writes land at the end of the strobe
    always @(posedge rw_n_i[s]) begin
      if (!mem_enable_n_i[s] && busy_n_o[s]) begin // Low busy level inhibits the write
        mem[addr_i[s]] = data_i[s];
        if (addr_i[s] == (s ? 13'h1FFE : 13'h1FFF))
          mail_flag_n_o[1-s] = 1'b0;
      end
      if (!token_space_select_n_i[s] && mem_enable_n_i[s])
        settle(s, addr_i[s][2:0], data_i[s][0]);
    end
    // Reading the own mailbox clears the own flag
    always @(negedge oe_n_i[s])
      if (!mem_enable_n_i[s] && addr_i[s] == (s ? 13'h1FFF : 13'h1FFE))
        mail_flag_n_o[s] = 1'b1;
    // Released bus shows the inverse so a stale value never passes
    always @*
      if (rd || !tr)
        hold[s] = rd ? mem[addr_i[s]] : tok[s];
    assign data_o[s] = (rd || !tr) ? hold[s] : ~hold[s];
  end
endmodule

/* tb/test_dpm_host.sv */
// Self-checking bench: two port controllers facing the memory model
`timescale 1ns/1ps
module test_dpm_host;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] cv = 2'b00, cw = 2'b00, ct = 2'b00;
  logic [12:0] ca [2] = '{13'h0, 13'h0};
  logic [7:0] cd [2] = '{8'h00, 8'h00};
  wire [1:0] rdy, rv, rb, mp, ce, sm, rw, oe, doe, bz, it, role;
  wire [12:0] pa [2];
  wire [7:0] rq [2], pd [2], pq [2];
  int n_errors = 0, total_checks = 0;

  // Left controller is master, right one is slave
  for (genvar s = 0; s < 2; s++) begin : g
    dpm_host #(.NUM_BUSY(1), .IS_LEFT(s == 0), .MAKE_MASTER(s == 0)) uut (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cv[s]), .cmd_write_i(cw[s]),
      .cmd_token_i(ct[s]), .cmd_addr_i(ca[s]), .cmd_wdata_i(cd[s]), .cmd_ready_o(rdy[s]),
      .rsp_valid_o(rv[s]), .rsp_rdata_o(rq[s]), .rsp_blocked_o(rb[s]),
      .mail_pending_o(mp[s]), .addr_o(pa[s]), .mem_enable_n_o(ce[s]),
      .token_space_select_n_o(sm[s]), .rw_n_o(rw[s]), .oe_n_o(oe[s]), .data_o(pd[s]),
      .data_oe_o(doe[s]), .data_i(pq[s]), .busy_n_i(bz[s:s]), .mail_flag_n_i(it[s]),
      .role_master_o(role[s]));
  end
  dpm_port_model dev (.addr_i(pa), .mem_enable_n_i(ce), .token_space_select_n_i(sm),
    .rw_n_i(rw), .oe_n_i(oe), .data_i(pd), .role_master_i(role[0]), .data_o(pq),
    .busy_n_o(bz), .mail_flag_n_o(it));

  // Clock, 4 ns period
  initial forever #2 mclk_i = ~mclk_i;

  // Verdict and exit, the single place the run ends
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compare with four-state equality
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up;
    n_errors++;
    $display("ERROR handshake expected 1 seen 0");
    end_of_test();
  endtask

  // One command on side s; all waits bounded
  task automatic op(input int s, input logic w, input logic t, input logic [12:0] a,
                    input logic [7:0] d, input bit timed, output logic [7:0] q);
    int n;
    @(negedge mclk_i);
    for (n = 0; rdy[s] !== 1'b1; n++) begin
      if (n > 500)
        give_up();
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    cv[s] <= 1'b1;
    cw[s] <= w;
    ct[s] <= t;
    ca[s] <= a;
    cd[s] <= d;
    @(posedge mclk_i);
    cv[s] <= 1'b0;
    @(negedge mclk_i);
    for (n = 0; rv[s] !== 1'b1; n++) begin
      if (n > 500)
        give_up();
      @(negedge mclk_i);
    end
    if (timed)
      chk("latency", w ? 8'h0D : 8'h0F, n[7:0]);
    chk("blocked", 8'h00, {7'h00, rb[s]});
    chk("standby", 8'h03, {6'h00, ce[s], sm[s]});
    q = rq[s];
  endtask

  // Procurement sequence on every token, high address bits scrambled
  task automatic t_tokens;
    logic [9:0] sd, vl, el, er;
    logic [7:0] q;
    logic [12:0] a;
    sd = 10'b0011010010;
    vl = 10'b1010110100;
    el = 10'b1011101100;
    er = 10'b1110110011;
    for (int i = 0; i < 8; i++) begin
      a = {10'h2AB, i[2:0]};
      op(0, 1'b1, 1'b1, a, 8'hFF, 1'b1, q);
      op(1, 1'b1, 1'b1, a, 8'hFF, 1'b1, q);
      for (int r = 0; r < 10; r++) begin
        op(int'(sd[r]), 1'b1, 1'b1, a, {7'h7F, vl[r]}, 1'b1, q);
        op(0, 1'b0, 1'b1, a, 8'h00, 1'b1, q);
        chk("token left", {8{el[r]}}, q);
        op(1, 1'b0, 1'b1, a, 8'h00, 1'b1, q);
        chk("token right", {8{er[r]}}, q);
      end
    end
    $display("t_tokens done");
  endtask

  // Each side posts to the other's mailbox, which reads it and clears the flag
  task automatic t_mail;
    logic [7:0] q;
    for (int s = 0; s < 2; s++) begin
      op(s, 1'b1, 1'b0, s ? 13'h1FFE : 13'h1FFF, 8'hA5 ^ s[7:0], 1'b1, q);
      chk("mail set", 8'h01, {7'h00, mp[1-s]});
      chk("mail other", 8'h00, {7'h00, mp[s]});
      op(1 - s, 1'b0, 1'b0, s ? 13'h1FFE : 13'h1FFF, 8'h00, 1'b1, q);
      chk("mail data", 8'hA5 ^ s[7:0], q);
      chk("mail clear", 8'h00, {7'h00, mp[1-s]});
    end
    $display("t_mail done");
  endtask

  // Same-address pairs launched together: left loses the tie and waits
  task automatic t_collide;
    logic [7:0] q0, q1;
    fork
      op(0, 1'b1, 1'b0, 13'h0123, 8'h3C, 1'b0, q0);
      op(1, 1'b1, 1'b0, 13'h0123, 8'hC3, 1'b0, q1);
    join
    op(1, 1'b0, 1'b0, 13'h0123, 8'h00, 1'b1, q1);
    chk("write collision", 8'h3C, q1);
    fork
      op(0, 1'b0, 1'b0, 13'h0123, 8'h00, 1'b0, q0);
      op(1, 1'b1, 1'b0, 13'h0123, 8'h5A, 1'b0, q1);
    join
    chk("read collision", 8'h5A, q0);
    $display("t_collide done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("role", 8'h01, {6'h00, role});
    t_tokens();
    t_mail();
    t_collide();
    end_of_test();
  end
endmodule
